/* File: core/slrc_regs.vh */
// slrc_regs.vh: offsets, field positions, reset values for the sleep retention bank
// assumes inclusion by the design files of the block
`ifndef SLRC_REGS_VH
`define SLRC_REGS_VH

// register indices, byte address is four times the index
`define SLRC_LDO_RET_IDX 6'h27
`define SLRC_CONV_RET_IDX 6'h28
`define SLRC_SHUT_IDX 6'h29
`define SLRC_STAT_IDX 6'h2c
// programmed defaults of the first variant
`define SLRC_LDO_RET_RST 8'he6
`define SLRC_CONV_RET_RST 8'h3b
`define SLRC_SHUT_RST 8'h19
// writable mask of the converter retention register
`define SLRC_CONV_WMASK 8'h3f
// field positions in the converter retention register
`define SLRC_LINREG9_BIT 0
`define SLRC_LINREG10_BIT 1
`define SLRC_BUCK1_BIT 2
`define SLRC_BUCK4_BIT 5
// number of controlled resources
`define SLRC_NRES 14
// axi response codes
`define SLRC_RESP_OKAY 2'h0
`define SLRC_RESP_SLVERR 2'h2

`endif

/* File: core/slrc_sync.v */
// slrc_sync.v: two flip-flop synchroniser for one level
// assumes the destination clock and an active-low async reset
`timescale 1ns/1ps
module slrc_sync (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // level in and out
   input wire d_i,
   output wire q_o
);
   reg meta_ff;
   reg sync_ff;

   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;
endmodule // slrc_sync

/* File: core/slrc_mode.v */
// slrc_mode.v: per-resource sleep regulation decision
// assumes sleep, retention and shutdown bits all in the clk_i domain
`timescale 1ns/1ps
module slrc_mode (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // controls
   input wire sleep_i,
   input wire stay_active_i,
   input wire shutdown_i,
   // mode outputs
   output reg economy_o,
   output reg off_o
);
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         economy_o <= 1'b0;
         off_o <= 1'b0;
      end else begin
         economy_o <= sleep_i & ~stay_active_i & ~shutdown_i; // R3 R4 R7
         off_o <= sleep_i & ~stay_active_i & shutdown_i; // R6 R7
      end
   end
endmodule // slrc_mode

/* File: core/slrc_top.v */
// slrc_top.v: sleep retention control registers with axi4-lite slave
// assumes a power sequencer drives the sleep request and reads the mode outputs
//
// Summary of operation
// (R1) Register 0x27 read/write, bits 0..7 keep linear regulators 1..8 active in sleep.
// (R2) Register 0x28: bits 0..1 regulators 9,10, bits 2..5 bucks 1..4, 7:6 read zero.
// (R3) Retention bit 0: resource goes to economy regulation while asleep.
// (R4) Retention bit 1: resource stays in normal active regulation while asleep.
// (R5) Power-on reset loads both registers with variant-specific programmed defaults.
// (R6) Shutdown bit 1 with retention bit 0: resource fully off in sleep.
// (R7) Outside sleep retention bits are ignored, every resource runs normally.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "slrc_regs.vh"
module slrc_top #(
   // programmed default values, one per device variant
   parameter [7:0] LDO_RET_DEFAULT = `SLRC_LDO_RET_RST,
   parameter [7:0] CONV_RET_DEFAULT = `SLRC_CONV_RET_RST,
   parameter [7:0] SHUT_DEFAULT = `SLRC_SHUT_RST
) (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   // sequencer link
   input wire sleep_i,
   output wire [13:0] economy_o,
   output wire [13:0] off_o
);
   reg rst_meta_ff;
   reg rst_sync_ff;
   wire rst_n;
   reg [7:0] aw_addr_ff;
   reg aw_full_ff;
   reg [7:0] w_data_ff;
   reg w_strb_ff;
   reg w_full_ff;
   reg [7:0] ldo_ret_ff;
   reg [7:0] conv_ret_ff;
   reg [7:0] shut_ff;
   reg [7:0] nxt_rdata;
   reg nxt_rok;
   reg wr_ok;
   wire do_write;
   wire wr_aligned;
   wire sleep_sync;
   wire [13:0] stay_vec;
   wire [13:0] shut_vec;
   wire [13:0] econ_vec;
   wire [13:0] offv_vec;

   // reset release through two flops
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   // sleep request from a pin
   slrc_sync u_sleep_sync (
      .clk_i(clk_i),
      .nrst_i(rst_n),
      .d_i(sleep_i),
      .q_o(sleep_sync)
   );

   // write channel capture, either order
   assign s_axi_awready_o = ~aw_full_ff & ~s_axi_bvalid_o;
   assign s_axi_wready_o = ~w_full_ff & ~s_axi_bvalid_o;
   assign do_write = aw_full_ff & w_full_ff & ~s_axi_bvalid_o;
   assign wr_aligned = (aw_addr_ff[1:0] == 2'b00);

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         aw_addr_ff <= 8'h00;
         aw_full_ff <= 1'b0;
         w_data_ff <= 8'h00;
         w_strb_ff <= 1'b0;
         w_full_ff <= 1'b0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_addr_ff <= s_axi_awaddr_i;
            aw_full_ff <= 1'b1;
         end else if (do_write) begin
            aw_full_ff <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_data_ff <= s_axi_wdata_i[7:0];
            w_strb_ff <= s_axi_wstrb_i[0];
            w_full_ff <= 1'b1;
         end else if (do_write) begin
            w_full_ff <= 1'b0;
         end
      end
   end

   // address decode for writes
   always @* begin
      case (aw_addr_ff[7:2])
         `SLRC_LDO_RET_IDX: wr_ok = 1'b1;
         `SLRC_CONV_RET_IDX: wr_ok = 1'b1;
         `SLRC_SHUT_IDX: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // register bank, defaults loaded at power-on reset
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ldo_ret_ff <= LDO_RET_DEFAULT; // R5
         conv_ret_ff <= CONV_RET_DEFAULT & `SLRC_CONV_WMASK; // R5
         shut_ff <= SHUT_DEFAULT;
      end else if (do_write && w_strb_ff && wr_aligned) begin
         if (aw_addr_ff[7:2] == `SLRC_LDO_RET_IDX) begin
            ldo_ret_ff <= w_data_ff; // R1
         end
         if (aw_addr_ff[7:2] == `SLRC_CONV_RET_IDX) begin
            conv_ret_ff <= w_data_ff & `SLRC_CONV_WMASK; // R2
         end
         if (aw_addr_ff[7:2] == `SLRC_SHUT_IDX) begin
            shut_ff <= w_data_ff;
         end
      end
   end

   // write response
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `SLRC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= (wr_ok && wr_aligned) ? `SLRC_RESP_OKAY
                                                               : `SLRC_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // read decode
   assign s_axi_arready_o = ~s_axi_rvalid_o;

   always @* begin
      nxt_rok = 1'b1;
      case (s_axi_araddr_i[7:2])
         `SLRC_LDO_RET_IDX: nxt_rdata = ldo_ret_ff; // R1
         `SLRC_CONV_RET_IDX: nxt_rdata = conv_ret_ff; // R2
         `SLRC_SHUT_IDX: nxt_rdata = shut_ff;
         `SLRC_STAT_IDX: nxt_rdata = {7'h00, sleep_sync};
         default: begin
            nxt_rdata = 8'h00;
            nxt_rok = 1'b0;
         end
      endcase
      // unaligned byte address answers zero with an error
      if (s_axi_araddr_i[1:0] != 2'b00) begin
         nxt_rdata = 8'h00;
         nxt_rok = 1'b0;
      end
   end

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h00000000;
         s_axi_rresp_o <= `SLRC_RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= {24'h000000, nxt_rdata};
         s_axi_rresp_o <= nxt_rok ? `SLRC_RESP_OKAY : `SLRC_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // resource vectors: linregs 1..10 then bucks 1..4
   assign stay_vec = {conv_ret_ff[`SLRC_BUCK4_BIT:`SLRC_LINREG9_BIT], ldo_ret_ff};
   assign shut_vec = {6'h00, shut_ff};

   genvar gi;
   generate
      for (gi = 0; gi < `SLRC_NRES; gi = gi + 1) begin : g_res
         slrc_mode u_mode (
            .clk_i(clk_i),
            .nrst_i(rst_n),
            .sleep_i(sleep_sync),
            .stay_active_i(stay_vec[gi]),
            .shutdown_i(shut_vec[gi]),
            .economy_o(econ_vec[gi]),
            .off_o(offv_vec[gi])
         );
      end
   endgenerate

   assign economy_o = econ_vec; // R3 R4 R7
   assign off_o = offv_vec; // R6
endmodule // slrc_top

/* File: tb/slrc_checker.sv */
// slrc_checker.sv: port assertions for the sleep retention bank
// assumes binding to slrc_top, one clock domain
`timescale 1ns/1ps
module slrc_checker (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // watched ports
   input wire sleep_i,
   input wire [13:0] economy_o,
   input wire [13:0] off_o,
   input wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_awake_no_eco: assert property ((!sleep_i) [*4] |-> economy_o == 14'h0)
      else $error("economy while awake");
   a_awake_no_off: assert property ((!sleep_i) [*4] |-> off_o == 14'h0)
      else $error("off while awake");
   a_eco_off_excl: assert property ((economy_o & off_o) == 14'h0)
      else $error("economy and off together");
   a_off_linreg_only: assert property (off_o[13:8] == 6'h0)
      else $error("off on resource without shutdown");
   a_bresp_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("write response not cleared");
   a_rresp_drop: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("read response not cleared");
   a_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read taken while answer pending");
   a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("write response dropped early");
   a_rresp_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
      else $error("read response dropped early");
   a_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
      else $error("upper read bits set");
   c_eco: cover property (economy_o != 14'h0);
   c_off: cover property (off_o != 14'h0);
   c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
   c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // slrc_checker
bind slrc_top slrc_checker i_chk (.*);

/* File: tb/slrc_seq_model.sv */
// slrc_seq_model.sv: power sequencer stand-in driving the sleep level
// assumes the bank clock; flags a resource both economy and off
`timescale 1ns/1ps
module slrc_seq_model (
   // clock and request
   input wire clk_i,
   input wire req_i,
   // mode inputs and sleep output
   input wire [13:0] economy_i,
   input wire [13:0] off_i,
   output reg sleep_o,
   output wire clash_o
);
   initial sleep_o = 1'b0;
   always @(posedge clk_i) sleep_o <= req_i;
   assign clash_o = |(economy_i & off_i);
endmodule // slrc_seq_model

/* File: tb/test_slrc_top.sv */
// test_slrc_top.sv: bench for the sleep retention bank
// assumes axi4-lite master role here, sequencer model on sleep
`timescale 1ns/1ps
module test_slrc_top;
   reg clk_i = 0, nrst_i = 0, req = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
   reg s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
   reg [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, r1, r2, r3;
   reg [31:0] s_axi_wdata_i = 0, x = 32'hdfd3;
   reg [33:0] q[$], e;
   reg ka, kw;
   wire [3:0] s_axi_wstrb_i = 4'h1;
   wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
   wire s_axi_rvalid_o, sleep_i, clash;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
   wire [31:0] s_axi_rdata_o;
   wire [13:0] economy_o, off_o;
   integer err_total = 0, checks_done = 0, i;
   localparam [5:0] I_LDO = 6'h27, I_CONV = 6'h28, I_SHUT = 6'h29, I_STAT = 6'h2c;
   localparam [7:0] A_LDO = {I_LDO, 2'b00}, A_CONV = {I_CONV, 2'b00};
   localparam [7:0] A_SHUT = {I_SHUT, 2'b00}, A_STAT = {I_STAT, 2'b00};
   slrc_top i_dut (.*);
   slrc_seq_model i_seq (.clk_i(clk_i), .req_i(req), .economy_i(economy_o),
      .off_i(off_o), .sleep_o(sleep_i), .clash_o(clash));
   initial forever #20 clk_i = ~clk_i;
   function [31:0] xs(input [31:0] v);
      reg [31:0] t;
      begin
         t = v ^ (v << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   task chk(input string n, input [33:0] ex, input [33:0] got);
      begin
         checks_done = checks_done + 1;
         if (got !== ex) begin
            err_total = err_total + 1;
            $display("MISMATCH %s exp %h got %h", n, ex, got);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d, input [1:0] rs);
      begin
         q.push_back({rs, 32'h0});
         @(posedge clk_i);
         s_axi_awaddr_i <= a;
         s_axi_wdata_i <= d;
         s_axi_awvalid_i <= 1'b1;
         s_axi_wvalid_i <= 1'b1;
         s_axi_bready_i <= 1'b1;
         @(negedge clk_i);
         while (s_axi_awvalid_i | s_axi_wvalid_i) begin
            ka = s_axi_awready_o & s_axi_awvalid_i;
            kw = s_axi_wready_o & s_axi_wvalid_i;
            @(posedge clk_i);
            if (ka) s_axi_awvalid_i <= 1'b0;
            if (kw) s_axi_wvalid_i <= 1'b0;
            @(negedge clk_i);
         end
         while (!s_axi_bvalid_o) @(negedge clk_i);
         @(posedge clk_i);
         s_axi_bready_i <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] d, input [1:0] rs);
      begin
         q.push_back({rs, d});
         @(posedge clk_i);
         s_axi_araddr_i <= a;
         s_axi_arvalid_i <= 1'b1;
         s_axi_rready_i <= 1'b1;
         @(negedge clk_i);
         while (!s_axi_arready_o) @(negedge clk_i);
         @(posedge clk_i);
         s_axi_arvalid_i <= 1'b0;
         @(negedge clk_i);
         while (!s_axi_rvalid_o) @(negedge clk_i);
         @(posedge clk_i);
         s_axi_rready_i <= 1'b0;
      end
   endtask
   task mode(input s, input [13:0] ee, input [13:0] eo);
      begin
         req <= s;
         repeat (6) @(posedge clk_i);
         @(negedge clk_i);
         chk("economy", ee, economy_o);
         chk("off", eo, off_o);
         chk("clash", 0, clash);
      end
   endtask
   always @(negedge clk_i) begin
      if (s_axi_bvalid_o && s_axi_bready_i) begin
         e = q.pop_front();
         chk("bresp", e[33:32], s_axi_bresp_o);
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
         e = q.pop_front();
         chk("read", e, {s_axi_rresp_o, s_axi_rdata_o});
      end
   end
   task close_out;
      begin
         $display("checks %0d mismatches %0d", checks_done, err_total);
         if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      #400000;
      err_total = err_total + 1;
      close_out;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rd(A_LDO, 32'he6, 2'h0);
      rd(A_CONV, 32'h3b, 2'h0);
      rd(A_SHUT, 32'h19, 2'h0);
      rd(8'h00, 32'h0, 2'h2);
      rd(A_LDO + 8'h01, 32'h0, 2'h2);
      wr(A_LDO + 8'h01, 32'h00, 2'h2);
      wr(8'h00, 32'h00, 2'h2);
      rd(A_LDO, 32'he6, 2'h0);
      wr(A_CONV, 32'hff, 2'h0);
      rd(A_CONV, 32'h3f, 2'h0);
      $display("register test done");
      for (i = 0; i < 6; i = i + 1) begin
         x = xs(x);
         r1 = x[7:0];
         r2 = x[15:8];
         r3 = x[23:16];
         wr(A_LDO, {24'h0, r1}, 2'h0);
         wr(A_CONV, {24'h0, r2}, 2'h0);
         wr(A_SHUT, {24'h0, r3}, 2'h0);
         rd(A_LDO, {24'h0, r1}, 2'h0);
         rd(A_CONV, {24'h0, r2 & 8'h3f}, 2'h0);
         rd(A_SHUT, {24'h0, r3}, 2'h0);
         mode(1'b1, {~r2[5:0], ~r1 & ~r3}, {6'h0, ~r1 & r3});
         rd(A_STAT, 32'h1, 2'h0);
         mode(1'b0, 14'h0, 14'h0);
         rd(A_STAT, 32'h0, 2'h0);
      end
      $display("sleep mode test done");
      close_out;
   end
endmodule // test_slrc_top
